// ### core/nt1af_line_fsm.sv
// Activation and deactivation state machine of the network termination.
// Assumes received line signals and T-side INFO arrive as decoded codes,
// synchronous to clk, from the line and T receivers of this device.
`timescale 1ns/10ps
`default_nettype none
`include "nt1af_regs.svh"

module nt1af_line_fsm #(
    parameter bit EARLY_FEBE = 1'b1   // Use SIG 14 rather than SIG 5 in T activation
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    // Line receiver side
    input  wire logic [`NT1AF_SIG_W-1:0]    rxSig,
    input  wire logic                       lineSynced,
    // T interface receiver side
    input  wire logic [`NT1AF_INFO_W-1:0]   rxInfo,
    input  wire logic                       tFrameLost,
    // Line transmitter side
    output logic [`NT1AF_SIG_W-1:0]         txSig,
    output nt1af_pkg::nt1af_ctrl_t          txCtrl,
    // T interface transmitter side
    output logic [`NT1AF_INFO_W-1:0]        txInfo,
    // Status
    output logic                            loop2On,
    output logic                            powerUp,
    output nt1af_pkg::nt1af_state_t         state
);

    // ****************************************
    // Decoded inputs
    // ****************************************
    logic gotSig1, gotSig3, gotSig4, gotSig6, gotSig7, gotSig9, gotSig13, gotSig15;
    logic gotInfo1, gotInfo3;
    assign gotSig1  = (rxSig == `NT1AF_SIG_1);
    assign gotSig3  = (rxSig == `NT1AF_SIG_3);
    assign gotSig4  = (rxSig == `NT1AF_SIG_4);
    assign gotSig6  = (rxSig == `NT1AF_SIG_6);
    assign gotSig7  = (rxSig == `NT1AF_SIG_7);
    assign gotSig9  = (rxSig == `NT1AF_SIG_9);
    assign gotSig13 = (rxSig == `NT1AF_SIG_13);
    assign gotSig15 = (rxSig == `NT1AF_SIG_15);
    assign gotInfo1 = (rxInfo == `NT1AF_INFO_1);
    assign gotInfo3 = (rxInfo == `NT1AF_INFO_3);

    // ****************************************
    // State transitions
    // ****************************************
    nt1af_pkg::nt1af_state_t state_q, state_d;

    // Next state from received signals
    always_comb begin
        state_d = state_q;
        if (gotSig1) begin
            state_d = nt1af_pkg::PowerDown;
        end else begin
            case (state_q)
                nt1af_pkg::PowerDown: begin
                    if (gotSig3) begin
                        state_d = nt1af_pkg::LineSync;
                    end else if (gotInfo1) begin
                        state_d = nt1af_pkg::AwakeInit;
                    end
                end
                nt1af_pkg::AwakeInit: begin
                    if (gotSig3) begin
                        state_d = nt1af_pkg::LineSync;
                    end
                end
                nt1af_pkg::LineSync: begin
                    if (lineSynced) begin
                        state_d = nt1af_pkg::Training;
                    end
                end
                nt1af_pkg::Training: begin
                    if (gotSig6) begin
                        state_d = nt1af_pkg::UniActivate;
                    end else if (gotSig9) begin
                        state_d = nt1af_pkg::Loop2;
                    end
                end
                nt1af_pkg::UniActivate: begin
                    if (gotSig4) begin
                        state_d = nt1af_pkg::Training;
                    end else if (gotSig13) begin
                        state_d = nt1af_pkg::TDeact;
                    end else if (gotInfo3) begin
                        state_d = nt1af_pkg::PendingAct;
                    end
                end
                nt1af_pkg::PendingAct: begin
                    if (gotSig4) begin
                        state_d = nt1af_pkg::Training;
                    end else if (gotSig13) begin
                        state_d = nt1af_pkg::TDeact;
                    end else if (gotSig7 && gotInfo3) begin
                        state_d = nt1af_pkg::AccessActive;
                    end
                end
                nt1af_pkg::AccessActive: begin
                    if (gotSig4) begin
                        state_d = nt1af_pkg::Training;
                    end else if (gotSig13) begin
                        state_d = nt1af_pkg::TDeact;
                    end else if (tFrameLost) begin
                        state_d = nt1af_pkg::UniActivate;
                    end
                end
                nt1af_pkg::TDeact: begin
                    // User INFO 1 is not looked at here
                    if (gotSig4) begin
                        state_d = nt1af_pkg::Training;
                    end else if (gotSig6) begin
                        state_d = nt1af_pkg::UniActivate;
                    end else if (gotSig9) begin
                        state_d = nt1af_pkg::Loop2;
                    end
                end
                nt1af_pkg::Loop2: begin
                    if (gotSig4) begin
                        state_d = nt1af_pkg::Training;
                    end else if (gotSig15) begin
                        state_d = nt1af_pkg::Loop2Off;
                    end
                end
                nt1af_pkg::Loop2Off: begin
                    if (gotSig4) begin
                        state_d = nt1af_pkg::Training;
                    end else if (gotSig9) begin
                        state_d = nt1af_pkg::Loop2;
                    end else if (gotSig6 || gotInfo1) begin
                        state_d = nt1af_pkg::UniActivate;
                    end
                end
                default: begin
                    state_d = nt1af_pkg::PowerDown;
                end
            endcase
        end
    end

    // ****************************************
    // Outputs per next state
    // ****************************************
    logic [`NT1AF_SIG_W-1:0]  txSig_d, txSig_q;
    logic [`NT1AF_INFO_W-1:0] txInfo_d, txInfo_q;
    nt1af_pkg::nt1af_ctrl_t   txCtrl_d, txCtrl_q;
    logic                     loop2On_d, loop2On_q, powerUp_d, powerUp_q;

    // Signal, INFO and control bits for the coming state
    always_comb begin
        txSig_d   = `NT1AF_SIG_0;
        txInfo_d  = `NT1AF_INFO_0;
        txCtrl_d  = '{ai: 1'b0, q: `NT1AF_Q_NONE, t: `NT1AF_T_NONE, febe: 1'b0, dataOnes: 1'b0, dataOp: 1'b0};
        loop2On_d = 1'b0;
        powerUp_d = 1'b1;
        case (state_d)
            nt1af_pkg::PowerDown: begin
                powerUp_d = 1'b0;
            end
            nt1af_pkg::AwakeInit: begin
                txSig_d   = `NT1AF_SIG_2A;
                powerUp_d = 1'b0;
            end
            nt1af_pkg::LineSync: begin
                txSig_d = `NT1AF_SIG_2A;
            end
            nt1af_pkg::Training: begin
                txSig_d = `NT1AF_SIG_5;
            end
            nt1af_pkg::UniActivate, nt1af_pkg::TDeact: begin
                if (EARLY_FEBE) begin
                    txSig_d       = `NT1AF_SIG_14;
                    txCtrl_d.q    = `NT1AF_Q_ALL;
                    txCtrl_d.febe = 1'b1;
                    txCtrl_d.dataOnes = 1'b1;
                end else begin
                    txSig_d = `NT1AF_SIG_5;
                end
                // INFO 2 inhibited while acknowledging T deactivate
                txInfo_d = (state_d == nt1af_pkg::TDeact) ? `NT1AF_INFO_0 : `NT1AF_INFO_2;
            end
            nt1af_pkg::PendingAct, nt1af_pkg::Loop2Off: begin
                txSig_d           = `NT1AF_SIG_8;
                txCtrl_d.ai       = 1'b1;
                txCtrl_d.q        = `NT1AF_Q_ALL;
                txCtrl_d.febe     = 1'b1;
                txCtrl_d.dataOnes = 1'b1;
                txInfo_d = (state_d == nt1af_pkg::PendingAct) ? `NT1AF_INFO_2 : `NT1AF_INFO_0;
            end
            nt1af_pkg::AccessActive: begin
                txSig_d         = `NT1AF_SIG_11;
                txCtrl_d.ai     = 1'b1;
                txCtrl_d.febe   = 1'b1;
                txCtrl_d.dataOp = 1'b1;
                txInfo_d        = `NT1AF_INFO_4;
            end
            nt1af_pkg::Loop2: begin
                txSig_d         = `NT1AF_SIG_10;
                txCtrl_d.ai     = 1'b1;
                txCtrl_d.t      = `NT1AF_T_ALL;
                txCtrl_d.febe   = 1'b1;
                txCtrl_d.dataOp = 1'b1;
                loop2On_d       = 1'b1;
            end
            default: begin
                powerUp_d = 1'b0;
            end
        endcase
    end

    // State and output registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= nt1af_pkg::PowerDown;
            txSig_q   <= `NT1AF_SIG_0;
            txInfo_q  <= `NT1AF_INFO_0;
            txCtrl_q  <= '0;
            loop2On_q <= 1'b0;
            powerUp_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            txSig_q   <= txSig_d;
            txInfo_q  <= txInfo_d;
            txCtrl_q  <= txCtrl_d;
            loop2On_q <= loop2On_d;
            powerUp_q <= powerUp_d;
        end
    end

    // Port drive
    assign state   = state_q;
    assign txSig   = txSig_q;
    assign txInfo  = txInfo_q;
    assign txCtrl  = txCtrl_q;
    assign loop2On = loop2On_q;
    assign powerUp = powerUp_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_deact_info0: assert property (gotSig13 && state_q == nt1af_pkg::AccessActive |=>
        txInfo == `NT1AF_INFO_0 && powerUp) else $error("T deactivate did not force INFO 0");
    chk_ignore_user: assert property (state_q == nt1af_pkg::TDeact && gotSig13 && !gotSig1 && !gotSig4
        |=> state_q == nt1af_pkg::TDeact) else $error("User activation taken during T deactivate");
    chk_lfa_resend: assert property (state_q == nt1af_pkg::AccessActive && tFrameLost && !gotSig1 &&
        !gotSig4 && !gotSig13 |=> txInfo == `NT1AF_INFO_2) else $error("T frame loss did not restart INFO 2");
    chk_ack_info0: assert property (state_q == nt1af_pkg::TDeact |-> txInfo == `NT1AF_INFO_0)
        else $error("INFO 2 sent while acknowledging T deactivate");
    chk_sig14_bits: assert property (txSig == `NT1AF_SIG_14 |-> txCtrl.q == `NT1AF_Q_ALL &&
        !txCtrl.ai && txCtrl.t == `NT1AF_T_NONE && txCtrl.febe) else $error("Bad bits in INFO 2 indication");
    chk_loop_release: assert property (state_q == nt1af_pkg::Loop2 && gotSig15 && !gotSig1 && !gotSig4
        |=> !loop2On && powerUp) else $error("Loopback 2 not released on deactivate");
    chk_info1_after: assert property (state_q == nt1af_pkg::Loop2Off && gotInfo1 && rxSig == `NT1AF_SIG_0
        |=> txInfo == `NT1AF_INFO_2) else $error("INFO 1 after loopback release not accepted");
    chk_powerdown: assert property (gotSig1 |=> txSig == `NT1AF_SIG_0 && txInfo == `NT1AF_INFO_0
        && !powerUp) else $error("Power down outputs wrong");
    chk_awake_send: assert property (state_q == nt1af_pkg::PowerDown && gotInfo1 && rxSig == `NT1AF_SIG_0
        |=> txSig == `NT1AF_SIG_2A [*1] ##1 (txSig == `NT1AF_SIG_2A || $past(gotSig1)))
        else $error("Awake not sent on INFO 1");
    chk_sync_only: assert property (state_q == nt1af_pkg::LineSync |-> txSig == `NT1AF_SIG_2A &&
        txInfo == `NT1AF_INFO_0) else $error("Extra signal during line sync");
    chk_train_out: assert property ($rose(state_q == nt1af_pkg::Training) |-> txSig == `NT1AF_SIG_5
        && $past(state_q) != nt1af_pkg::PowerDown) else $error("Training not sent after sync");
    chk_uni_start: assert property (state_q == nt1af_pkg::Training && gotSig6 && !gotSig1 |=>
        txInfo == `NT1AF_INFO_2 && (txSig == `NT1AF_SIG_14 || !EARLY_FEBE)) else $error("T activation not begun");
    chk_no_early4: assert property (state_q == nt1af_pkg::PendingAct && !gotSig7 |=>
        txInfo != `NT1AF_INFO_4) else $error("INFO 4 before normal operation signal");
    chk_normal_ans: assert property (state_q == nt1af_pkg::PendingAct && gotSig7 && gotInfo3 && !gotSig1
        && !gotSig4 && !gotSig13 |=> txSig == `NT1AF_SIG_11 && txCtrl.dataOp) else $error("No normal operation answer");

    // Per-state output checks
    chk_tdeact_ack: assert property (state_q == nt1af_pkg::TDeact |->
        txSig == (EARLY_FEBE ? `NT1AF_SIG_14 : `NT1AF_SIG_5)) else $error("T deactivate not acknowledged");
    chk_alt_train: assert property (!EARLY_FEBE && state_q == nt1af_pkg::UniActivate |->
        txSig == `NT1AF_SIG_5) else $error("Training not sent in place of INFO 2 indication");
    chk_pend_info2: assert property ($rose(state_q == nt1af_pkg::PendingAct) |-> txSig == `NT1AF_SIG_8 &&
        txInfo == `NT1AF_INFO_2 && txCtrl.ai) else $error("Receipt indication outputs wrong");
    chk_access_info4: assert property (state_q == nt1af_pkg::AccessActive |-> txSig == `NT1AF_SIG_11 &&
        txInfo == `NT1AF_INFO_4) else $error("Normal operation outputs wrong");
    chk_train_idle: assert property (state_q == nt1af_pkg::Training |-> txInfo == `NT1AF_INFO_0 &&
        !loop2On) else $error("Training state outputs wrong");
    chk_loop_outputs: assert property (state_q == nt1af_pkg::Loop2 |-> loop2On &&
        txInfo == `NT1AF_INFO_0) else $error("Loopback 2 outputs wrong");

    // Power down entry and hold
    chk_sig1_wins: assert property (gotSig1 |=> state_q == nt1af_pkg::PowerDown)
        else $error("Line deactivate did not power down");
    chk_pd_wait: assert property (state_q == nt1af_pkg::PowerDown && !gotSig3 && !gotInfo1 |=>
        state_q == nt1af_pkg::PowerDown) else $error("Left power down without a wake up");

    cov_user_act: cover property (state_q == nt1af_pkg::AwakeInit ##[1:50] state_q == nt1af_pkg::AccessActive);
    cov_t_deact:  cover property (state_q == nt1af_pkg::AccessActive ##1 state_q == nt1af_pkg::TDeact);
    cov_loop_rel: cover property (state_q == nt1af_pkg::Loop2 ##1 state_q == nt1af_pkg::Loop2Off
        ##[1:20] state_q == nt1af_pkg::UniActivate);
    cov_frame_loss: cover property (state_q == nt1af_pkg::AccessActive && tFrameLost
        ##1 state_q == nt1af_pkg::UniActivate);
    cov_loop_entry: cover property (state_q == nt1af_pkg::Training ##1 state_q == nt1af_pkg::Loop2);

endmodule : nt1af_line_fsm
`default_nettype wire

// ### core/nt1af_pkg.sv
// Types for the line activation controller.
// Assumes nt1af_regs.svh is included by the users of this package.
package nt1af_pkg;

    // ****************************************
    // Controller states
    // ****************************************
    typedef enum logic [3:0] {
        PowerDown,     // NT 1.0
        AwakeInit,     // NT 1.1
        LineSync,      // NT 1.2
        Training,      // NT 1.3
        UniActivate,   // NT 1.4
        PendingAct,    // NT 1.5
        AccessActive,  // Normal operation
        TDeact,        // T interface held off by the LT
        Loop2,         // Loopback 2 operated
        Loop2Off       // Loopback 2 released, line active
    } nt1af_state_t;

    // ****************************************
    // Control-channel bits sent toward the LT
    // ****************************************
    typedef struct packed {
        logic       ai;        // Activation indication bit
        logic [3:0] q;         // Q1..Q4 bits
        logic [2:0] t;         // T1..T3 bits
        logic       febe;      // FEBE reporting on
        logic       dataOnes;  // 2B+D all ones
        logic       dataOp;    // 2B+D operational data
    } nt1af_ctrl_t;

endpackage : nt1af_pkg

// ### core/nt1af_regs.svh
// Constants for the line activation controller: line signal codes,
// T-interface INFO codes and field widths.
// Assumes the line receiver and T receiver decode their signals into these codes.
//
// Overview of operation
// - On T deactivate, send INFO 0 and keep the line active.
// - While T deactivate is received, user activation is ignored.
// - Send INFO 2 indication when T activation starts or T frame is lost.
// - INFO 2 indication acknowledging T deactivate goes with INFO 0.
// - INFO 2 indication carries FEBE, Q1 to Q4 set, data all ones.
// - Training signal may replace INFO 2 indication when early FEBE is unneeded.
// - On loopback deactivate, release loopback 2 and keep the line active.
// - After loopback release, INFO 1 from user starts T activation.
// - Power down: no line signal, INFO 0, wait INFO 1 or awake.
// - On INFO 1 in power down, send awake and wait acknowledgement.
// - On awake acknowledgement, send awake only while syncing to training.
// - Once synchronized, send training and wait line active or loopback.
// - On line active, send INFO 2 and its indication, wait INFO 3.
// - On INFO 3, send receipt indication, wait normal operation first.
// - On normal operation signal, answer with normal operation and data.
`ifndef NT1AF_REGS_SVH
`define NT1AF_REGS_SVH

// Code widths
`define NT1AF_SIG_W    5
`define NT1AF_INFO_W   3

// Line signal codes (received and sent)
`define NT1AF_SIG_0    5'h00
`define NT1AF_SIG_1    5'h01
`define NT1AF_SIG_2A   5'h02
`define NT1AF_SIG_3    5'h03
`define NT1AF_SIG_4    5'h04
`define NT1AF_SIG_5    5'h05
`define NT1AF_SIG_6    5'h06
`define NT1AF_SIG_7    5'h07
`define NT1AF_SIG_8    5'h08
`define NT1AF_SIG_9    5'h09
`define NT1AF_SIG_10   5'h0a
`define NT1AF_SIG_11   5'h0b
`define NT1AF_SIG_13   5'h0d
`define NT1AF_SIG_14   5'h0e
`define NT1AF_SIG_15   5'h0f

// T-interface INFO codes
`define NT1AF_INFO_0   3'h0
`define NT1AF_INFO_1   3'h1
`define NT1AF_INFO_2   3'h2
`define NT1AF_INFO_3   3'h3
`define NT1AF_INFO_4   3'h4

// Control-channel field values
`define NT1AF_Q_ALL    4'hf
`define NT1AF_Q_NONE   4'h0
`define NT1AF_T_ALL    3'h7
`define NT1AF_T_NONE   3'h0

`endif

// ### tb/nt1_line_activation_fsm_bench.sv
// Self-checking bench of the NT1 activation state machine.
// Assumes nt1af_pkg is compiled first and the header is on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "nt1af_regs.svh"

module nt1_line_activation_fsm_bench;
    typedef nt1af_pkg::nt1af_state_t nt1af_st_t;
    logic                     clk        = 1'b0;
    logic                     rst_n      = 1'b0;
    logic [`NT1AF_SIG_W-1:0]  cmdSig     = `NT1AF_SIG_0;
    logic                     lineSynced = 1'b0;
    logic [`NT1AF_INFO_W-1:0] rxInfo     = `NT1AF_INFO_0;
    logic                     tFrameLost = 1'b0;
    logic [`NT1AF_SIG_W-1:0]  rxSig;
    logic [`NT1AF_SIG_W-1:0]  txSig;
    logic [`NT1AF_SIG_W-1:0]  txSigAlt;
    logic                     tActRpt;
    logic [`NT1AF_INFO_W-1:0] txInfo;
    nt1af_pkg::nt1af_ctrl_t   txCtrl;
    nt1af_pkg::nt1af_ctrl_t   ctrlExp;
    logic                     loop2On;
    logic                     powerUp;
    nt1af_st_t                state;
    int                       err_total  = 0;
    int                       tests_run  = 0;
    int                       cycles     = 0;

    // Clock
    always #5 clk = ~clk;

    // ****************************************
    // Design and far end
    // ****************************************
    nt1af_line_fsm nt1af_line_fsm_inst (.clk(clk), .rst_n(rst_n), .rxSig(rxSig), .lineSynced(lineSynced),
        .rxInfo(rxInfo), .tFrameLost(tFrameLost), .txSig(txSig), .txCtrl(txCtrl), .txInfo(txInfo),
        .loop2On(loop2On), .powerUp(powerUp), .state(state));
    nt1af_line_fsm #(.EARLY_FEBE(1'b0)) nt1af_line_fsm_inst2 (.clk(clk), .rst_n(rst_n), .rxSig(rxSig),
        .lineSynced(lineSynced), .rxInfo(rxInfo), .tFrameLost(tFrameLost), .txSig(txSigAlt), .txCtrl(),
        .txInfo(), .loop2On(), .powerUp(), .state());
    nt1af_lt_model nt1af_lt_model_inst (.clk(clk), .rst_n(rst_n), .cmdSig(cmdSig), .rxSig(rxSig), .txSig(txSig),
        .tActRpt(tActRpt));

    // ****************************************
    // Compare and drive tasks
    // ****************************************
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    task automatic cmp_code(input string what, input logic [4:0] exp, input logic [4:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_code

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask : cmp_bit

    task automatic cmp_state(input nt1af_st_t exp);
        tests_run++;
        if (state !== exp) begin
            err_total++;
            $display("BAD state expected %0d seen %0d", exp, state);
        end
    endtask : cmp_state

    task automatic cmp_ctrl(input nt1af_pkg::nt1af_ctrl_t exp);
        tests_run++;
        if (txCtrl !== exp) begin
            err_total++;
            $display("BAD txCtrl expected %h seen %h", exp, txCtrl);
        end
    endtask : cmp_ctrl

    // Apply line request and T-side levels at a rising edge
    task automatic drive(input logic [4:0] sig, input logic [2:0] info, input logic sync, input logic lost);
        @(posedge clk);
        cmdSig     <= sig;
        rxInfo     <= info;
        lineSynced <= sync;
        tFrameLost <= lost;
    endtask : drive

    // Wait a bounded time for a state, then check both outgoing codes
    task automatic reach(input nt1af_st_t exp, input logic [4:0] sig, input logic [2:0] info);
        int n;
        n = 0;
        #1;
        while (state !== exp && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        cmp_state(exp);
        cmp_code("txSig", sig, txSig);
        cmp_code("txInfo", {2'b00, info}, {2'b00, txInfo});
    endtask : reach

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_user_act();
        drive(`NT1AF_SIG_0, `NT1AF_INFO_1, 1'b0, 1'b0);
        reach(nt1af_pkg::AwakeInit, `NT1AF_SIG_2A, `NT1AF_INFO_0);
        drive(`NT1AF_SIG_0, `NT1AF_INFO_0, 1'b0, 1'b0);
        reach(nt1af_pkg::LineSync, `NT1AF_SIG_2A, `NT1AF_INFO_0);
        cmp_bit("powerUp", 1'b1, powerUp);
        drive(`NT1AF_SIG_0, `NT1AF_INFO_0, 1'b1, 1'b0);
        reach(nt1af_pkg::Training, `NT1AF_SIG_5, `NT1AF_INFO_0);
        drive(`NT1AF_SIG_6, `NT1AF_INFO_0, 1'b1, 1'b0);
        reach(nt1af_pkg::UniActivate, `NT1AF_SIG_14, `NT1AF_INFO_2);
        ctrlExp = '{ai: 1'b0, q: 4'hf, t: 3'h0, febe: 1'b1, dataOnes: 1'b1, dataOp: 1'b0};
        cmp_ctrl(ctrlExp);
        cmp_code("txSigAlt", `NT1AF_SIG_5, txSigAlt);
        drive(`NT1AF_SIG_6, `NT1AF_INFO_3, 1'b1, 1'b0);
        reach(nt1af_pkg::PendingAct, `NT1AF_SIG_8, `NT1AF_INFO_2);
        repeat (3) @(posedge clk);
        #1;
        cmp_state(nt1af_pkg::PendingAct);
        drive(`NT1AF_SIG_7, `NT1AF_INFO_3, 1'b1, 1'b0);
        reach(nt1af_pkg::AccessActive, `NT1AF_SIG_11, `NT1AF_INFO_4);
        cmp_bit("ai", 1'b1, txCtrl.ai);
        @(posedge clk);
        #1;
        cmp_bit("tActRpt", 1'b1, tActRpt);
    endtask : t_user_act

    task automatic t_frame_and_tdeact();
        drive(`NT1AF_SIG_7, `NT1AF_INFO_3, 1'b1, 1'b1);
        reach(nt1af_pkg::UniActivate, `NT1AF_SIG_14, `NT1AF_INFO_2);
        drive(`NT1AF_SIG_7, `NT1AF_INFO_3, 1'b1, 1'b0);
        reach(nt1af_pkg::AccessActive, `NT1AF_SIG_11, `NT1AF_INFO_4);
        drive(`NT1AF_SIG_13, `NT1AF_INFO_3, 1'b1, 1'b0);
        reach(nt1af_pkg::TDeact, `NT1AF_SIG_14, `NT1AF_INFO_0);
        drive(`NT1AF_SIG_13, `NT1AF_INFO_1, 1'b1, 1'b0);
        repeat (4) @(posedge clk);
        #1;
        cmp_state(nt1af_pkg::TDeact);
        cmp_bit("powerUp", 1'b1, powerUp);
        drive(`NT1AF_SIG_6, `NT1AF_INFO_0, 1'b1, 1'b0);
        reach(nt1af_pkg::UniActivate, `NT1AF_SIG_14, `NT1AF_INFO_2);
    endtask : t_frame_and_tdeact

    task automatic t_loop2();
        drive(`NT1AF_SIG_1, `NT1AF_INFO_0, 1'b0, 1'b0);
        reach(nt1af_pkg::PowerDown, `NT1AF_SIG_0, `NT1AF_INFO_0);
        cmp_bit("powerUp", 1'b0, powerUp);
        cmp_bit("tActRpt", 1'b0, tActRpt);
        drive(`NT1AF_SIG_3, `NT1AF_INFO_0, 1'b0, 1'b0);
        reach(nt1af_pkg::LineSync, `NT1AF_SIG_2A, `NT1AF_INFO_0);
        drive(`NT1AF_SIG_3, `NT1AF_INFO_0, 1'b1, 1'b0);
        reach(nt1af_pkg::Training, `NT1AF_SIG_5, `NT1AF_INFO_0);
        drive(`NT1AF_SIG_9, `NT1AF_INFO_0, 1'b1, 1'b0);
        reach(nt1af_pkg::Loop2, `NT1AF_SIG_10, `NT1AF_INFO_0);
        cmp_bit("loop2On", 1'b1, loop2On);
        drive(`NT1AF_SIG_15, `NT1AF_INFO_0, 1'b1, 1'b0);
        reach(nt1af_pkg::Loop2Off, `NT1AF_SIG_8, `NT1AF_INFO_0);
        cmp_bit("loop2On", 1'b0, loop2On);
        cmp_bit("powerUp", 1'b1, powerUp);
        drive(`NT1AF_SIG_0, `NT1AF_INFO_1, 1'b1, 1'b0);
        reach(nt1af_pkg::UniActivate, `NT1AF_SIG_14, `NT1AF_INFO_2);
    endtask : t_loop2

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            give_verdict();
        end
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        #1;
        reach(nt1af_pkg::PowerDown, `NT1AF_SIG_0, `NT1AF_INFO_0);
        cmp_bit("powerUp", 1'b0, powerUp);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        cmp_state(nt1af_pkg::PowerDown);
        t_user_act();
        t_frame_and_tdeact();
        t_loop2();
        give_verdict();
    end
endmodule : nt1_line_activation_fsm_bench
`default_nettype wire

// ### tb/nt1af_lt_model.sv
// Behavioural line termination facing the NT1 over the line.
// Assumes the bench names the line signal to send; code 0 means idle.
`timescale 1ns/10ps
`default_nettype none
`include "nt1af_regs.svh"

module nt1af_lt_model #(
    parameter int ACK_DLY = 4   // Cycles before an awake is acknowledged
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // Exchange side request
    input  wire logic [`NT1AF_SIG_W-1:0] cmdSig,
    // Line towards and from the NT1
    output logic [`NT1AF_SIG_W-1:0]      rxSig,
    input  wire logic [`NT1AF_SIG_W-1:0] txSig,
    // Report toward the exchange
    output logic                         tActRpt
);
    int ackCnt;

    // ****************************************
    // Line transmitter
    // ****************************************
    // Requested signal goes out framed; idle line answers an awake after a delay
    // Exchange timers stay outside this model
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxSig  <= `NT1AF_SIG_0;
            ackCnt <= 0;
        end else if (cmdSig != `NT1AF_SIG_0 || txSig != `NT1AF_SIG_2A) begin
            rxSig  <= cmdSig;
            ackCnt <= 0;
        end else begin
            ackCnt <= ackCnt + 1;
            rxSig  <= (ackCnt >= ACK_DLY) ? `NT1AF_SIG_3 : `NT1AF_SIG_0;
        end
    end

    // T or loopback activated report, one cycle after the NT1 answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tActRpt <= 1'b0;
        end else begin
            tActRpt <= (txSig == `NT1AF_SIG_11) || (txSig == `NT1AF_SIG_10);
        end
    end
endmodule : nt1af_lt_model
`default_nettype wire
